/* src/mwts_pkg.sv */
package mwts_pkg;
	// Bus geometry
	localparam int DATA_W = 32;
	localparam int ADDR_W = 12;
	localparam int STRB_W = DATA_W / 8;
	// Register indices; byte address is four times the index
	localparam logic [6:0] IDX_DELTA_FIRST = 7'h70;
	localparam logic [6:0] IDX_DELTA_LAST = 7'h77;
	localparam logic [6:0] IDX_SEG_SEL = 7'h78;
	localparam logic [6:0] IDX_COIL_VAL = 7'h7A;
	localparam logic [6:0] IDX_START = 7'h7E;
	// Reset values
	localparam logic [31:0] SEG_SEL_RESET = 32'hFFFF_8056;
	localparam logic [7:0] SINE_START_RESET = 8'h00;
	localparam logic [7:0] COSINE_START_RESET = 8'hF7;
	// Field positions
	localparam int SINE_LSB = 0;
	localparam int COSINE_LSB = 16;
	localparam int BORDER1_LSB = 8;
	localparam int BORDER2_LSB = 16;
	localparam int BORDER3_LSB = 24;
	localparam int INCLINE_W = 2;
	localparam int COIL_A_LSB = 0;
	localparam int COIL_B_LSB = 16;
	// Wave geometry
	localparam int POS_W = 10;
	localparam int IDX_W = 8;
	localparam int WAVE_W = 9;
	localparam int INC_W = 3;
	localparam int TABLE_WORDS = 8;
	localparam logic [9:0] PHASE_SHIFT = 10'h100;
	typedef enum logic [1:0] {
		MWTS_IDLE,
		MWTS_FETCH,
		MWTS_APPLY
	} mwts_state_t;
endpackage

/* src/mwts_delta_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module mwts_delta_mem #(
	parameter int WORDS = 8
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [$clog2(WORDS)-1:0] wr_word,
	input wire logic [mwts_pkg::STRB_W-1:0] wr_strb,
	input wire logic [mwts_pkg::DATA_W-1:0] wr_data,
	input wire logic [$clog2(WORDS)-1:0] rd_word,
	output logic [mwts_pkg::DATA_W-1:0] rd_data,
	input wire logic [$clog2(WORDS*32)-1:0] bit_idx_a,
	output logic bit_a,
	input wire logic [$clog2(WORDS*32)-1:0] bit_idx_b,
	output logic bit_b
);
	import mwts_pkg::*;
	logic [WORDS*DATA_W-1:0] cells;
	logic [WORDS*DATA_W-1:0] next_cells;

	// Only power-of-two word counts map onto the bit index cleanly
	if (WORDS < 1 || (WORDS & (WORDS - 1)) != 0)
		$error("mwts_delta_mem: WORDS must be a power of two");

	// Byte-lane merge of one word
	always_comb begin
		next_cells = cells;
		for (int b = 0; b < STRB_W; b++) begin
			if (wr_en && wr_strb[b])
				next_cells[int'(wr_word)*DATA_W+b*8 +: 8] = wr_data[b*8 +: 8];
		end
	end

	// Cleared table after reset; reads come out registered
	always_ff @(posedge mclk) begin
		if (srst) begin
			cells <= '0;
			rd_data <= '0;
			bit_a <= 1'b0;
			bit_b <= 1'b0;
		end else begin
			cells <= next_cells;
			rd_data <= cells[int'(rd_word)*DATA_W +: DATA_W];
			bit_a <= cells[bit_idx_a];
			bit_b <= cells[bit_idx_b];
		end
	end
endmodule
`default_nettype wire

/* src/mwts_incline.sv */
`timescale 1ns/1ps
`default_nettype none
module mwts_incline (
	input wire logic [mwts_pkg::IDX_W-1:0] idx,
	input wire logic ofs,
	input wire logic [mwts_pkg::DATA_W-1:0] seg_sel,
	output logic signed [mwts_pkg::INC_W-1:0] inc
);
	import mwts_pkg::*;
	logic [INCLINE_W-1:0] w;
	logic [IDX_W-1:0] b1;
	logic [IDX_W-1:0] b2;
	logic [IDX_W-1:0] b3;

	assign b1 = seg_sel[BORDER1_LSB +: IDX_W];
	assign b2 = seg_sel[BORDER2_LSB +: IDX_W];
	assign b3 = seg_sel[BORDER3_LSB +: IDX_W];

	// Segment pick: a border entry already belongs to the upper segment
	always_comb begin
		if (idx < b1)
			w = seg_sel[0 +: INCLINE_W];
		else if (idx < b2)
			w = seg_sel[2 +: INCLINE_W];
		else if (idx < b3)
			w = seg_sel[4 +: INCLINE_W];
		else
			w = seg_sel[6 +: INCLINE_W];
	end

	// Lower or upper of two adjacent steps; base 0 wraps to -1
	assign inc = INC_W'({1'b0, w} + {2'b00, ofs} - 3'd1);
endmodule
`default_nettype wire

/* src/mwts_sequencer.sv */
// Overview of operation
// - Start value of first wave sits in bits 7:0 at index 0x7E.
// - Start value of shifted second wave sits in bits 23:16 at 0x7E.
// - Segment select at index 0x78 resets to 0xFFFF8056.
// - Default: border one at 128, inclination 2 then 1.
// - Default table adds 1 or 2 below 128, 0 or 1 above.
// - Inclination 3 steps by +2 or +3.
// - Inclination 0 steps by -1 or 0.
// - Delta bit 0 picks lower increment, 1 picks higher.
// - Standard table: first wave starts at 0, second at 247.
// - Next entry equals previous plus inclination, minus one if bit clear.
// - Both coil values reload from start values when the walk position reaches zero.
// - Segment select holds four inclinations and three 8-bit borders.
// - 256 delta bits live in eight words at 0x70 to 0x77.
`timescale 1ns/1ps
`default_nettype none
module mwts_sequencer (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [mwts_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mwts_pkg::DATA_W-1:0] pwdata,
	input wire logic [mwts_pkg::STRB_W-1:0] pstrb,
	output logic [mwts_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [mwts_pkg::POS_W-1:0] microstep_position,
	output logic signed [mwts_pkg::WAVE_W-1:0] coil_a_value,
	output logic signed [mwts_pkg::WAVE_W-1:0] coil_b_value
);
	import mwts_pkg::*;

	localparam int WORD_W = $clog2(TABLE_WORDS);

	// Bus side state
	logic [DATA_W-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// Software registers
	logic [DATA_W-1:0] segment_select;
	logic [DATA_W-1:0] next_segment_select;
	logic [7:0] sine_start_value;
	logic [7:0] next_sine_start_value;
	logic [7:0] cosine_start_value;
	logic [7:0] next_cosine_start_value;

	// Sequencer state
	mwts_state_t state;
	mwts_state_t next_state;
	logic [POS_W-1:0] walk_pos;
	logic [POS_W-1:0] next_walk_pos;
	logic [POS_W-1:0] look_pos;
	logic [POS_W-1:0] next_look_pos;
	logic dir_up;
	logic next_dir_up;
	logic signed [WAVE_W-1:0] next_coil_a_value;
	logic signed [WAVE_W-1:0] next_coil_b_value;

	// Decode and table wiring
	logic [6:0] reg_idx;
	logic addr_ok;
	logic hit_delta;
	logic hit_seg;
	logic hit_coil;
	logic hit_start;
	logic acc_done;
	logic wr_acc;
	logic [DATA_W-1:0] table_word;
	logic [DATA_W-1:0] start_word;
	logic [DATA_W-1:0] coil_word;
	logic [POS_W-1:0] look_b;
	logic [IDX_W-1:0] idx_a;
	logic [IDX_W-1:0] idx_b;
	logic neg_a;
	logic neg_b;
	logic ofs_a;
	logic ofs_b;
	logic signed [INC_W-1:0] inc_a;
	logic signed [INC_W-1:0] inc_b;
	logic signed [WAVE_W-1:0] step_a;
	logic signed [WAVE_W-1:0] step_b;
	logic [POS_W-1:0] pos_diff;

	// Byte-lane merge for register writes
	function automatic logic [DATA_W-1:0] merge(
		input logic [DATA_W-1:0] old,
		input logic [DATA_W-1:0] wd,
		input logic [STRB_W-1:0] st
	);
		logic [DATA_W-1:0] res;
		res = old;
		for (int b = 0; b < STRB_W; b++) begin
			if (st[b])
				res[b*8 +: 8] = wd[b*8 +: 8];
		end
		return res;
	endfunction

	// Address decode; misaligned or high addresses are unmapped
	assign reg_idx = paddr[8:2];
	assign addr_ok = (paddr[ADDR_W-1:9] == '0) && (paddr[1:0] == 2'b00);
	assign hit_delta = addr_ok && reg_idx >= IDX_DELTA_FIRST &&
		reg_idx <= IDX_DELTA_LAST;
	assign hit_seg = addr_ok && reg_idx == IDX_SEG_SEL;
	assign hit_coil = addr_ok && reg_idx == IDX_COIL_VAL;
	assign hit_start = addr_ok && reg_idx == IDX_START;
	assign acc_done = psel && penable && pready;
	assign wr_acc = acc_done && pwrite;

	// Read views; unused start bits read zero, coil fields are sign-extended to 16 bits
	always_comb begin
		start_word = '0;
		start_word[SINE_LSB +: 8] = sine_start_value;
		start_word[COSINE_LSB +: 8] = cosine_start_value;
		coil_word = '0;
		coil_word[COIL_A_LSB +: 16] = 16'(coil_a_value);
		coil_word[COIL_B_LSB +: 16] = 16'(coil_b_value);
	end

	// Delta table; registered read gives one wait state on every access
	mwts_delta_mem #(
		.WORDS(TABLE_WORDS)
	) u_delta_mem (
		.mclk(mclk),
		.srst(srst),
		.wr_en(wr_acc && hit_delta),
		.wr_word(reg_idx[WORD_W-1:0]),
		.wr_strb(pstrb),
		.wr_data(pwdata),
		.rd_word(reg_idx[WORD_W-1:0]),
		.rd_data(table_word),
		.bit_idx_a(idx_a),
		.bit_a(ofs_a),
		.bit_idx_b(idx_b),
		.bit_b(ofs_b)
	);

	// APB answer: pready rises in the second access cycle
	always_comb begin
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = '0;
		if (psel && penable && !pready) begin
			next_pready = 1'b1;
			next_pslverr = !(hit_delta || hit_seg || hit_coil || hit_start);
			if (!pwrite) begin
				if (hit_delta)
					next_prdata = table_word;
				else if (hit_seg)
					next_prdata = segment_select;
				else if (hit_coil)
					next_prdata = coil_word;
				else if (hit_start)
					next_prdata = start_word;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// Writes land only on the completing edge; coil values are read-only
	always_comb begin
		next_segment_select = segment_select;
		next_sine_start_value = sine_start_value;
		next_cosine_start_value = cosine_start_value;
		if (wr_acc && hit_seg)
			next_segment_select = merge(segment_select, pwdata, pstrb);
		if (wr_acc && hit_start && pstrb[SINE_LSB/8])
			next_sine_start_value = pwdata[SINE_LSB +: 8];
		if (wr_acc && hit_start && pstrb[COSINE_LSB/8])
			next_cosine_start_value = pwdata[COSINE_LSB +: 8];
	end

	// Defaults give the standard two-segment sine table
	always_ff @(posedge mclk) begin
		if (srst) begin
			segment_select <= SEG_SEL_RESET;
			sine_start_value <= SINE_START_RESET;
			cosine_start_value <= COSINE_START_RESET;
		end else begin
			segment_select <= next_segment_select;
			sine_start_value <= next_sine_start_value;
			cosine_start_value <= next_cosine_start_value;
		end
	end

	// Quadrant mapping: odd quadrants mirror, quadrants 1 and 2 negate
	assign look_b = look_pos + PHASE_SHIFT;
	assign idx_a = look_pos[8] ? ~look_pos[7:0] : look_pos[7:0];
	assign idx_b = look_b[8] ? ~look_b[7:0] : look_b[7:0];
	assign neg_a = look_pos[9] ^ look_pos[8];
	assign neg_b = look_b[9] ^ look_b[8];

	mwts_incline u_incline_a (
		.idx(idx_a),
		.ofs(ofs_a),
		.seg_sel(segment_select),
		.inc(inc_a)
	);

	mwts_incline u_incline_b (
		.idx(idx_b),
		.ofs(ofs_b),
		.seg_sel(segment_select),
		.inc(inc_b)
	);

	// Signed step toward the next higher position
	assign step_a = neg_a ? -WAVE_W'(inc_a) : WAVE_W'(inc_a);
	assign step_b = neg_b ? -WAVE_W'(inc_b) : WAVE_W'(inc_b);
	assign pos_diff = microstep_position - walk_pos;

	// One position per three cycles, shortest way round the circle
	always_comb begin
		next_state = state;
		next_walk_pos = walk_pos;
		next_look_pos = look_pos;
		next_dir_up = dir_up;
		next_coil_a_value = coil_a_value;
		next_coil_b_value = coil_b_value;
		unique case (state)
			MWTS_IDLE: begin
				if (pos_diff != '0) begin
					next_dir_up = !pos_diff[POS_W-1];
					next_look_pos = pos_diff[POS_W-1] ? walk_pos - 1'b1 : walk_pos;
					next_state = MWTS_FETCH;
				end
			end
			MWTS_FETCH: begin
				// Table bits for look_pos are sampled this cycle
				next_state = MWTS_APPLY;
			end
			MWTS_APPLY: begin
				next_state = MWTS_IDLE;
				if (dir_up) begin
					next_walk_pos = walk_pos + 1'b1;
					next_coil_a_value = coil_a_value + step_a;
					next_coil_b_value = coil_b_value + step_b;
				end else begin
					next_walk_pos = walk_pos - 1'b1;
					next_coil_a_value = coil_a_value - step_a;
					next_coil_b_value = coil_b_value - step_b;
				end
				// Absolute reload cures drift after table edits
				if (next_walk_pos == '0) begin
					next_coil_a_value = WAVE_W'(sine_start_value);
					next_coil_b_value = WAVE_W'(cosine_start_value);
				end
			end
		endcase
	end

	// Reset starts at position zero with the start values loaded
	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= MWTS_IDLE;
			walk_pos <= '0;
			look_pos <= '0;
			dir_up <= 1'b1;
			coil_a_value <= WAVE_W'(SINE_START_RESET);
			coil_b_value <= WAVE_W'(COSINE_START_RESET);
		end else begin
			state <= next_state;
			walk_pos <= next_walk_pos;
			look_pos <= next_look_pos;
			dir_up <= next_dir_up;
			coil_a_value <= next_coil_a_value;
			coil_b_value <= next_coil_b_value;
		end
	end
endmodule
`default_nettype wire

/* verification/mwts_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mwts_sequencer_properties (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [mwts_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mwts_pkg::DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic signed [mwts_pkg::WAVE_W-1:0] coil_a_value,
	input wire logic signed [mwts_pkg::WAVE_W-1:0] coil_b_value
);
	import mwts_pkg::*;
	// Single clock domain, so clock and reset are given once
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// Bus answer comes after exactly one wait state
	chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not in second access cycle");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// Misaligned or out of range addresses are refused
	chk_err_misalign: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access not refused");
	chk_err_high: assert property (pready && paddr[11:9] != 3'h0 |-> pslverr)
		else $error("high address not refused");
	chk_seg_no_err: assert property (pready && paddr == 12'h1E0 |-> !pslverr)
		else $error("segment select access refused");
	// Read data is clean outside the answer cycle
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero while idle");
	chk_coil_reset: assert property ($fell(srst) |->
		coil_a_value == 9'sd0 && coil_b_value == 9'sd247)
		else $error("coil values wrong after reset");
endmodule
bind mwts_sequencer mwts_sequencer_properties chk (.mclk(mclk), .srst(srst),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.coil_a_value(coil_a_value), .coil_b_value(coil_b_value));
`default_nettype wire

/* verification/microstep_wave_table_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module microstep_wave_table_sequencer_test;
	import mwts_pkg::*;
	logic mclk = 0;
	logic srst = 1;
	logic [ADDR_W-1:0] paddr = '0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [STRB_W-1:0] pstrb = 4'hF;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [POS_W-1:0] pos = '0;
	logic signed [WAVE_W-1:0] coil_a;
	logic signed [WAVE_W-1:0] coil_b;
	logic due = 0;
	logic [32:0] rd_q[$];
	logic [17:0] coil_q[$];
	int errors = 0;
	int total_checks = 0;
	integer seed = 88;
	logic [31:0] rnd;

	// 250 MHz
	always #2 mclk = ~mclk;

	mwts_sequencer uut (.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.microstep_position(pos), .coil_a_value(coil_a),
		.coil_b_value(coil_b));

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watcher takes the oldest note whenever a result shows
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
			check({pslverr, prdata}, rd_q.pop_front());
		// Both coils at once, so the shifted wave is covered too
		if (due && coil_q.size() > 0)
			check({15'h0, coil_a, coil_b}, {15'h0, coil_q.pop_front()});
	end

	// One transfer; an idle edge after it keeps drivers single per step
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		psel <= 0;
		penable <= 0;
		if (pready !== 1'b1) begin
			errors++;
			print_verdict();
		end
		@(posedge mclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		rd_q.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	// Step waits the caller's walk latency of c cycles before the coil is looked at
	task automatic step(input logic [9:0] p, input logic [8:0] e,
		input logic [8:0] eb, input int c);
		pos <= p;
		coil_q.push_back({e, eb});
		repeat (c) @(posedge mclk);
		due <= 1;
		@(posedge mclk);
		due <= 0;
	endtask

	initial begin
		rnd = $random(seed);
		repeat (4) @(posedge mclk);
		srst <= 0;
		@(posedge mclk);
		rd(12'h1E0, {1'b0, SEG_SEL_RESET});
		rd(12'h1F8, 33'h0_00F7_0000);
		rd(12'h1E8, 33'h0_00F7_0000);
		// Unmapped index and misaligned byte address
		rd(12'h1E4, 33'h1_0000_0000);
		rd(12'h1E1, 33'h1_0000_0000);
		apb(1'b1, 12'h1C4, rnd);
		rd(12'h1C4, {1'b0, rnd});
		// Delta bits 1, 3 and 5 set, the rest of word 0 clear
		apb(1'b1, 12'h1C0, 32'h0000_002A);
		step(10'd1, 9'd1, 9'd247, 5);
		step(10'd2, 9'd3, 9'd247, 5);
		// Two segments only: unused borders at 255, unused slopes as W1
		apb(1'b1, 12'h1E0, 32'hFFFF_8003);
		step(10'd3, 9'd5, 9'd248, 5);
		step(10'd4, 9'd8, 9'd249, 5);
		// Border at zero puts every index in the upper segment
		apb(1'b1, 12'h1E0, 32'hFFFF_0053);
		rd(12'h1E0, 33'h0_FFFF_0053);
		step(10'd5, 9'd7, 9'd250, 5);
		step(10'd6, 9'd7, 9'd251, 5);
		apb(1'b1, 12'h1F8, 32'h0012_0034);
		step(10'd0, 9'h034, 9'h012, 30);
		rd(12'h1F8, 33'h0_0012_0034);
		rd(12'h1E8, 33'h0_0012_0034);
		// Index bits above the map must not alias
		rd(12'h3E0, 33'h1_0000_0000);
		// Only the cosine lane enabled; sine start must keep its value
		pstrb <= 4'h4;
		apb(1'b1, 12'h1F8, 32'h0055_0066);
		pstrb <= 4'hF;
		rd(12'h1F8, 33'h0_0055_0034);
		// Reset in mid-run restores defaults over programmed values
		srst <= 1;
		repeat (2) @(posedge mclk);
		srst <= 0;
		@(posedge mclk);
		rd(12'h1F8, 33'h0_00F7_0000);
		rd(12'h1E8, 33'h0_00F7_0000);
		rd(12'h1E0, {1'b0, SEG_SEL_RESET});
		rd(12'h1C4, 33'h0_0000_0000);
		print_verdict();
	end
endmodule
`default_nettype wire
